// file: hdl/nfh_ctrl.sv
// Host sequencer that drives the NAND flash pins one bus cycle per request but a busy wait, or three or five cycles per address request.
// Assumes io_in and rb_n_in come from pads; the bench resolves the wires.
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl
  import nfh_pkg::*;
#(
  parameter int BUSY_LIMIT_CYC = BUSY_LIMIT_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  req_valid,
  input  wire nfh_req_t              req,
  output logic                       req_ready,
  input  wire logic                  wp_allow,
  output var nfh_pins_t              pins,
  input  wire logic [7:0]            io_in,
  input  wire logic                  rb_n_in,
  output var nfh_rsp_t               rsp,
  output wire logic [ECC_CODE_W-1:0] ecc_code,
  output wire logic                  ecc_valid
);
  // ----------------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WR_LO  = 3'b001,
    ST_WR_HI  = 3'b011,
    ST_DONE   = 3'b010,
    ST_RD_LO  = 3'b110,
    ST_RD_HI  = 3'b111,
    ST_SETTLE = 3'b101,
    ST_BUSY   = 3'b100
  } nfh_state_t;

  nfh_state_t        state_reg;
  nfh_op_t           op_reg;
  logic [3:0]        cnt_reg;
  logic [23:0]       busy_cnt_reg;
  logic [2:0]        abyte_reg;
  logic [COL_W-1:0]  col_reg;
  logic [ROW_W-1:0]  row_reg;
  logic [7:0]        io_s1_reg;
  logic [7:0]        io_s2_reg;
  logic              rb_s1_reg;
  logic              rb_s2_reg;
  logic              taken;
  logic              ecc_stb;
  logic              ecc_clr;

  // ----------------------------------------------------------------------
  // Pad synchronisers
  // ----------------------------------------------------------------------
  // Two stages on every pad input; only the second stage is read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else begin
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= rb_n_in;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // A request other than a busy wait is held back while the flash is busy.
  assign taken = req_valid && req_ready &&
                 (req.op == NFH_OP_WAIT || rb_s2_reg);
  assign ecc_stb = (state_reg == ST_WR_HI && cnt_reg == 4'h0 &&
                    op_reg == NFH_OP_WDATA) ||
                   (state_reg == ST_RD_LO && cnt_reg == 4'h0);
  assign ecc_clr = taken && req.op == NFH_OP_ADDR5;

  // ----------------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------------
  // Steps through write, read and busy-wait cycles and drives every pin.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      op_reg       <= NFH_OP_CMD;
      cnt_reg      <= 4'h0;
      busy_cnt_reg <= 24'h000000;
      abyte_reg    <= 3'h0;
      col_reg      <= '0;
      row_reg      <= '0;
      req_ready    <= 1'b0;
      rsp          <= '0;
      pins         <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                        read_strobe_n: 1'b1, wp_n: 1'b0, io_oe_n: 1'b1,
                        io_out: 8'h00};
    end else begin
      pins.wp_n <= wp_allow;
      rsp.done  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          pins.ce_n <= 1'b1;
          req_ready <= 1'b1;
          if (taken) begin
            req_ready   <= 1'b0;
            op_reg      <= req.op;
            col_reg     <= req.col;
            row_reg     <= req.row;
            rsp.timeout <= 1'b0;
            pins.ce_n   <= 1'b0;
            case (req.op)
              NFH_OP_CMD, NFH_OP_WDATA: begin
                pins.cle     <= (req.op == NFH_OP_CMD);
                pins.io_out  <= req.data;
                pins.io_oe_n <= 1'b0;
                pins.we_n    <= 1'b0;
                cnt_reg      <= 4'(WE_LOW_CYC - 1);
                state_reg    <= ST_WR_LO;
              end
              NFH_OP_ADDR5, NFH_OP_ADDR3: begin
                // Full address starts at the column, erase at the row.
                abyte_reg    <= (req.op == NFH_OP_ADDR5) ? 3'h0 :
                                3'(ADDR_FIRST_ROW_BYTE);
                pins.io_out  <= nfh_addr_byte((req.op == NFH_OP_ADDR5) ?
                                3'h0 : 3'(ADDR_FIRST_ROW_BYTE),
                                req.col, req.row);
                pins.ale     <= 1'b1;
                pins.io_oe_n <= 1'b0;
                pins.we_n    <= 1'b0;
                cnt_reg      <= 4'(WE_LOW_CYC - 1);
                state_reg    <= ST_WR_LO;
              end
              NFH_OP_RDATA: begin
                pins.read_strobe_n <= 1'b0;
                cnt_reg            <= 4'(RE_LOW_CYC - 1);
                state_reg          <= ST_RD_LO;
              end
              default: begin
                cnt_reg   <= 4'(BUSY_SETTLE_CYC - 1);
                state_reg <= ST_SETTLE;
              end
            endcase
          end
        end
        ST_WR_LO: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0) begin
            pins.we_n <= 1'b1; // Rising edge latches the byte.
            cnt_reg   <= 4'(WE_HIGH_CYC - 1);
            state_reg <= ST_WR_HI;
          end
        end
        ST_WR_HI: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0) begin
            if (pins.ale && abyte_reg != 3'(ADDR_LAST_BYTE)) begin
              abyte_reg   <= abyte_reg + 3'h1;
              pins.io_out <= nfh_addr_byte(abyte_reg + 3'h1, col_reg,
                                           row_reg);
              pins.we_n   <= 1'b0;
              cnt_reg     <= 4'(WE_LOW_CYC - 1);
              state_reg   <= ST_WR_LO;
            end else begin
              pins.cle     <= 1'b0;
              pins.ale     <= 1'b0;
              pins.io_oe_n <= 1'b1;
              state_reg    <= ST_DONE;
            end
          end
        end
        ST_RD_LO: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0) begin
            rsp.data           <= io_s2_reg;
            pins.read_strobe_n <= 1'b1;
            cnt_reg            <= 4'(RE_HIGH_CYC - 1);
            state_reg          <= ST_RD_HI;
          end
        end
        ST_RD_HI: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_DONE;
          end
        end
        ST_SETTLE: begin
          cnt_reg      <= cnt_reg - 4'h1;
          busy_cnt_reg <= 24'h000000;
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          busy_cnt_reg <= busy_cnt_reg + 24'h000001;
          if (rb_s2_reg) begin
            state_reg <= ST_DONE;
          end else if (busy_cnt_reg == 24'(BUSY_LIMIT_CYC - 1)) begin
            rsp.timeout <= 1'b1;
            state_reg   <= ST_DONE;
          end
        end
        default: begin
          rsp.done  <= 1'b1;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Code generator over written and read page bytes.
  nfh_ecc u_ecc (
    .clk        (clk),
    .reset_n    (reset_n),
    .clear      (ecc_clr),
    .byte_valid (ecc_stb),
    .byte_data  (op_reg == NFH_OP_RDATA ? io_s2_reg : pins.io_out),
    .code       (ecc_code),
    .code_valid (ecc_valid)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [3:0] re_gap_reg;
  logic [2:0] ale_cnt_reg;

  // Helpers: cycles since the last read strobe fall, address bytes sent.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      re_gap_reg  <= 4'hf;
      ale_cnt_reg <= 3'h0;
    end else begin
      if ($fell(pins.read_strobe_n)) re_gap_reg <= 4'h1;
      else if (re_gap_reg != 4'hf) re_gap_reg <= re_gap_reg + 4'h1;
      if (taken) ale_cnt_reg <= 3'h0;
      else if ($rose(pins.we_n) && pins.ale) ale_cnt_reg <= ale_cnt_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_cmd_latch: assert property ($rose(pins.we_n) && pins.cle |->
    !pins.ale && !pins.io_oe_n && pins.io_out == $past(pins.io_out))
    else $error("Command latched without stable command byte.");
  chk_addr_latch: assert property ($rose(pins.we_n) && pins.ale |->
    !pins.cle && pins.io_out == nfh_addr_byte(abyte_reg, col_reg, row_reg))
    else $error("Address byte does not match its position.");
  chk_col_order: assert property ($rose(pins.we_n) && pins.ale &&
    abyte_reg == 3'h0 |-> pins.io_out == col_reg[7:0])
    else $error("First address byte is not column low.");
  chk_page_bits: assert property ($rose(pins.we_n) && pins.ale &&
    abyte_reg == 3'h2 |-> pins.io_out[5:0] == row_reg[5:0])
    else $error("Page bits misplaced in third address byte.");
  chk_block_plane: assert property ($rose(pins.we_n) && pins.ale &&
    abyte_reg == 3'h3 |-> pins.io_out == row_reg[15:8])
    else $error("Block bits misplaced in fourth address byte.");
  chk_zero_pad: assert property ($rose(pins.we_n) && pins.ale &&
    (abyte_reg == 3'h1 || abyte_reg == 3'h4) |->
    (abyte_reg == 3'h1 ? pins.io_out[7:4] == 4'h0 :
                         pins.io_out[7:2] == 6'h00))
    else $error("Unused address bits not zero.");
  chk_read_rate: assert property ($fell(pins.read_strobe_n) |->
    $past(re_gap_reg) >= 4'(READ_CYCLE_CYC))
    else $error("Read strobe cycles faster than allowed.");
  chk_select_write: assert property ($fell(pins.we_n) |->
    !pins.ce_n [*2])
    else $error("Write strobe pulsed while deselected.");
  chk_full_addr: assert property (rsp.done && op_reg == NFH_OP_ADDR5 |->
    ale_cnt_reg == 3'(ADDR_FULL_BYTES))
    else $error("Full address did not send five bytes.");
  chk_row_addr: assert property (rsp.done && op_reg == NFH_OP_ADDR3 |->
    ale_cnt_reg == 3'(ADDR_ROW_BYTES))
    else $error("Row address did not send three bytes.");
  chk_busy_hold: assert property (state_reg == ST_IDLE && req_valid &&
    req.op != NFH_OP_WAIT && !rb_s2_reg |=> state_reg == ST_IDLE)
    else $error("Operation started while flash busy.");

  cov_full_addr: cover property (rsp.done && op_reg == NFH_OP_ADDR5);
  cov_read_byte: cover property (rsp.done && op_reg == NFH_OP_RDATA);
  // Done follows two cycles after the busy watch ends, via the done state.
  cov_busy_wait: cover property (state_reg == ST_BUSY ##2 rsp.done);
endmodule : nfh_ctrl
`default_nettype wire

// file: inc/nfh_pkg.sv
// Constants, types and address helper for the host-side NAND flash pin
// sequencer. Assumes a 100 MHz clock and one byte-wide flash device.
package nfh_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS               = 10;
  localparam int WE_LOW_NS            = 15;
  localparam int WE_HIGH_NS           = 10;
  localparam int WE_LOW_CYC           = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC          = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYCLE_NS        = 25;
  localparam int READ_CYCLE_CYC       = (READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_ACCESS_DELAY_NS = 20;
  localparam int SYNC_STAGES          = 2;
  localparam int RE_LOW_CYC           =
    (READ_ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int RE_HIGH_CYC          = 1;
  localparam int BUSY_SETTLE_NS       = 100;
  localparam int BUSY_SETTLE_CYC      = (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_READ_MAX_US     = 25;
  localparam int PROGRAM_TYP_US       = 250;
  localparam int ERASE_TYP_US         = 2000;
  localparam int BUSY_MARGIN          = 4;
  localparam int BUSY_LIMIT_DEF       =
    ERASE_TYP_US * 1000 / CLK_NS * BUSY_MARGIN;
  // ----------------------------------------------------------------------
  // Geometry and address layout
  // ----------------------------------------------------------------------
  localparam int PAGE_DATA_BYTES      = 2048;
  localparam int PAGE_SPARE_BYTES     = 64;
  localparam int PAGE_BYTES           = PAGE_DATA_BYTES + PAGE_SPARE_BYTES;
  localparam int COL_W                = 12;
  localparam int ROW_W                = 18;
  localparam int ADDR_LAST_BYTE       = 4;
  localparam int ADDR_FIRST_ROW_BYTE  = 2;
  localparam int ADDR_FULL_BYTES      = 5;
  localparam int ADDR_ROW_BYTES       = 3;
  localparam int ECC_CHUNK_BYTES      = 528;
  localparam int ECC_IDX_W            = 10;
  localparam int ECC_CODE_W           = 2 * ECC_IDX_W + 6;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    NFH_OP_CMD   = 3'h0,
    NFH_OP_ADDR5 = 3'h1,
    NFH_OP_ADDR3 = 3'h2,
    NFH_OP_WDATA = 3'h3,
    NFH_OP_RDATA = 3'h4,
    NFH_OP_WAIT  = 3'h5
  } nfh_op_t;
  typedef struct packed {
    nfh_op_t           op;
    logic [7:0]        data;
    logic [COL_W-1:0]  col;
    logic [ROW_W-1:0]  row;
  } nfh_req_t;
  typedef struct packed {
    logic       done;
    logic       timeout;
    logic [7:0] data;
  } nfh_rsp_t;
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic       io_oe_n;
    logic [7:0] io_out;
  } nfh_pins_t;
  // Byte idx of the five-byte address: column low, column high, then row.
  function automatic logic [7:0] nfh_addr_byte(input logic [2:0] idx,
                                               input logic [COL_W-1:0] col,
                                               input logic [ROW_W-1:0] row);
    case (idx)
      3'h0:    nfh_addr_byte = col[7:0];
      3'h1:    nfh_addr_byte = {4'h0, col[11:8]};
      3'h2:    nfh_addr_byte = row[7:0];
      3'h3:    nfh_addr_byte = row[15:8];
      default: nfh_addr_byte = {6'h00, row[17:16]};
    endcase
  endfunction : nfh_addr_byte
endpackage : nfh_pkg

// file: hdl/nfh_ecc.sv
// Parity code generator over 528-byte portions of page data.
// Assumes byte strobes from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module nfh_ecc
  import nfh_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  clear,
  input  wire logic                  byte_valid,
  input  wire logic [7:0]            byte_data,
  output logic      [ECC_CODE_W-1:0] code,
  output logic                       code_valid
);
  localparam logic [ECC_IDX_W-1:0] LAST_IDX = ECC_IDX_W'(ECC_CHUNK_BYTES - 1);
  localparam logic [7:0] COL_MASK [3] = '{8'hf0, 8'hcc, 8'haa};

  logic [ECC_IDX_W-1:0]  idx_reg;
  logic [ECC_CODE_W-1:0] acc_reg;
  logic [ECC_CODE_W-1:0] delta;
  logic                  byte_par;

  // Line parity halves by byte index bit, column parity by bit position.
  assign byte_par = ^byte_data;
  genvar k;
  generate
    for (k = 0; k < ECC_IDX_W; k++) begin : g_line
      assign delta[6+ECC_IDX_W+k] = byte_par & idx_reg[k];
      assign delta[6+k]           = byte_par & ~idx_reg[k];
    end
    for (k = 0; k < 3; k++) begin : g_col
      assign delta[3+k] = ^(byte_data & COL_MASK[2-k]);
      assign delta[k]   = ^(byte_data & ~COL_MASK[2-k]);
    end
  endgenerate

  // Accumulate and emit one code per full portion.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_reg    <= '0;
      acc_reg    <= '0;
      code       <= '0;
      code_valid <= 1'b0;
    end else begin
      code_valid <= 1'b0;
      if (clear) begin
        idx_reg <= '0;
        acc_reg <= '0;
      end else if (byte_valid) begin
        if (idx_reg == LAST_IDX) begin
          code       <= acc_reg ^ delta;
          code_valid <= 1'b1;
          acc_reg    <= '0;
          idx_reg    <= '0;
        end else begin
          acc_reg <= acc_reg ^ delta;
          idx_reg <= idx_reg + 1'b1;
        end
      end
    end
  end

  chk_ecc_chunk_end: assert property (@(posedge clk) disable iff (!reset_n)
    code_valid |-> $past(idx_reg) == LAST_IDX && $past(byte_valid))
    else $error("ECC code emitted before a full portion.");
endmodule : nfh_ecc
`default_nettype wire

// file: tb/nfh_flash_model.sv
// Behavioural NAND flash device facing the host pin sequencer.
// Assumes the bench resolves the data wire and pulls ready/busy up.
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int READ_NS   = 600,
  parameter int PROG_NS   = 900,
  parameter int ERASE_NS  = 1200,
  parameter int ACCESS_NS = 15
) (
  input  wire nfh_pins_t  pins,
  input  wire logic [7:0] io_bus,
  input  wire logic       slow,
  output logic [7:0]      io_q,
  output logic            io_drive,
  output logic            busy
);
  logic [7:0]       page_reg [PAGE_BYTES];
  logic [7:0]       mem      [int][int];
  logic [COL_W-1:0] col;
  logic [ROW_W-1:0] row;
  int               aidx;
  int               bad_pad;
  int               fast_rd;
  realtime          last_fall;
  // Start idle with an empty array.
  initial begin
    busy = 1'b0;
    io_q = 8'h00;
    col = '0;
    row = '0;
    aidx = 0;
    bad_pad = 0;
    fast_rd = 0;
    last_fall = -100.0;
  end
  // Data lines are driven only while selected and strobed.
  assign io_drive = !pins.ce_n && !pins.read_strobe_n && !busy;
  // Busy runs on its own timer, so deselection cannot cut it short.
  task automatic start_op(input int ns);
    busy = 1'b1;
    fork
      #(slow ? ns * 10 : ns) busy = 1'b0;
    join_none
  endtask : start_op
  // Bytes are latched on the write strobe's rising edge only.
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && !busy) begin
      if (pins.cle) begin
        aidx = (io_bus == 8'h60) ? ADDR_FIRST_ROW_BYTE : 0;
        case (io_bus)
          8'h80: foreach (page_reg[i]) page_reg[i] = 8'hff;
          8'h30: begin
            foreach (page_reg[i])
              page_reg[i] = (mem.exists(int'(row)) &&
                mem[int'(row)].exists(i)) ? mem[int'(row)][i] : 8'hff;
            start_op(READ_NS);
          end
          8'h10: begin
            if (pins.wp_n)
              foreach (page_reg[i]) mem[int'(row)][i] = page_reg[i];
            start_op(PROG_NS);
          end
          8'hd0: begin
            if (pins.wp_n)
              for (int p = 0; p < 64; p++)
                mem.delete(int'({row[17:6], 6'h00}) + p);
            start_op(ERASE_NS);
          end
          default: ;
        endcase
      end else if (pins.ale) begin
        case (aidx)
          0: col[7:0] = io_bus;
          1: begin
            col[11:8] = io_bus[3:0];
            if (io_bus[7:4] != 4'h0) bad_pad++;
          end
          2: row[7:0] = io_bus;
          3: row[15:8] = io_bus;
          4: begin
            row[17:16] = io_bus[1:0];
            if (io_bus[7:2] != 6'h00) bad_pad++;
          end
          default: ;
        endcase
        aidx++;
      end else begin
        page_reg[col] = io_bus;
        col = col + 1'b1;
      end
    end
  end
  // Each falling read strobe shows the byte at the column, then advances.
  always @(negedge pins.read_strobe_n) begin
    if (!pins.ce_n && !busy) begin
      if ($realtime - last_fall < 25.0) fast_rd++;
      last_fall = $realtime;
      io_q <= #(ACCESS_NS) page_reg[col];
      col = col + 1'b1;
    end
  end
endmodule : nfh_flash_model
`default_nettype wire

// file: tb/nand_flash_bus_interface_bench.sv
// Self-checking bench: sequencer, flash model and a reference page store.
// Assumes the package, the sequencer and the flash model compile first.
`timescale 1ns/1ps
`default_nettype none
module nand_flash_bus_interface_bench
  import nfh_pkg::*;
;
  logic                  clk;
  logic                  reset_n;
  logic                  req_valid;
  nfh_req_t              req;
  logic                  req_ready;
  logic                  wp_allow;
  nfh_pins_t             pins;
  logic [7:0]            io_in;
  logic                  rb_n_in;
  nfh_rsp_t              rsp;
  logic [ECC_CODE_W-1:0] ecc_code;
  logic                  ecc_valid;
  logic [7:0]            io_q;
  logic                  io_drive;
  logic                  busy;
  logic                  slow;
  logic [7:0]            idle_pat;
  logic [7:0]            rd;
  logic                  to;
  logic [ROW_W-1:0]      r_a;
  logic [ROW_W-1:0]      r_c;
  logic [ECC_CODE_W-1:0] ecc_first;
  logic [7:0]            exp_mem [int][int];
  int                    failures;
  int                    checked;
  int                    ecc_pulses;
  // ----------------------------------------------------------------------
  // Clock, wires and instances
  // ----------------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // A released data wire shows a changing pattern, never the last byte.
  always @(posedge clk) idle_pat <= idle_pat + 8'h01;
  always @(posedge clk) if (ecc_valid === 1'b1) ecc_pulses++;
  assign io_in = !pins.io_oe_n ? pins.io_out : io_drive ? io_q : idle_pat;
  assign rb_n_in = !busy;
  nfh_ctrl #(.BUSY_LIMIT_CYC(200)) u_nfh_ctrl (
    .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .wp_allow(wp_allow), .pins(pins),
    .io_in(io_in), .rb_n_in(rb_n_in), .rsp(rsp), .ecc_code(ecc_code),
    .ecc_valid(ecc_valid));
  nfh_flash_model u_nfh_flash_model (
    .pins(pins), .io_bus(io_in), .slow(slow), .io_q(io_q),
    .io_drive(io_drive), .busy(busy));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  function automatic logic [7:0] exp_byte(input int r, input int c);
    return (exp_mem.exists(r) && exp_mem[r].exists(c)) ? exp_mem[r][c]
                                                        : 8'hff;
  endfunction : exp_byte
  // One request: wait for ready, hold until taken, then wait for done.
  task automatic do_req(input nfh_op_t op, input logic [7:0] d,
                        input int c, input logic [ROW_W-1:0] r);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req = '{op, d, COL_W'(c), r};
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b0 && n < 9000);
    req_valid = 1'b0;
    if (op != NFH_OP_WAIT) check("idle at take", busy, 0);
    while (rsp.done !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    check("done", rsp.done, 1);
    rd = rsp.data;
    to = rsp.timeout;
  endtask : do_req
  task automatic addr(input logic [ROW_W-1:0] r, input int c, input bit full);
    do_req(full ? NFH_OP_ADDR5 : NFH_OP_ADDR3, 8'h00, c, r);
    if (full) check("column", u_nfh_flash_model.col, c);
    check("row", u_nfh_flash_model.row, r);
    check("addr bytes", u_nfh_flash_model.aidx, 5);
  endtask : addr
  task automatic wait_ok(input logic exp_to);
    do_req(NFH_OP_WAIT, 8'h00, 0, '0);
    check("busy timeout", to, exp_to);
  endtask : wait_ok
  task automatic prog(input logic [ROW_W-1:0] r, input int c, input int n);
    logic [7:0] b;
    if (wp_allow) exp_mem.delete(int'(r));
    do_req(NFH_OP_CMD, 8'h80, 0, '0);
    addr(r, c, 1'b1);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      if (wp_allow) exp_mem[int'(r)][c + i] = b;
      do_req(NFH_OP_WDATA, b, 0, '0);
    end
    do_req(NFH_OP_CMD, 8'h10, 0, '0);
    wait_ok(1'b0);
  endtask : prog
  task automatic readback(input logic [ROW_W-1:0] r, input int c,
                          input int n);
    do_req(NFH_OP_CMD, 8'h00, 0, '0);
    addr(r, c, 1'b1);
    do_req(NFH_OP_CMD, 8'h30, 0, '0);
    wait_ok(1'b0);
    for (int i = 0; i < n; i++) begin
      do_req(NFH_OP_RDATA, 8'h00, 0, '0);
      check("read byte", rd, exp_byte(int'(r), c + i));
    end
  endtask : readback
  task automatic erase(input logic [ROW_W-1:0] r);
    for (int p = 0; p < 64; p++)
      exp_mem.delete(int'({r[17:6], 6'h00}) + p);
    do_req(NFH_OP_CMD, 8'h60, 0, '0);
    addr(r, 0, 1'b0);
    do_req(NFH_OP_CMD, 8'hd0, 0, '0);
  endtask : erase
  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    wp_allow = 1'b1;
    slow = 1'b0;
    idle_pat = 8'h5a;
    failures = 0;
    checked = 0;
    ecc_pulses = 0;
    void'($urandom(32'h55a22ffe));
    repeat (16) @(negedge clk);
    check("pins in reset", pins, 15'h4d00);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    r_a = {1'b0, 10'($urandom), 1'b0, 6'($urandom)};
    r_c = r_a | 18'h20000;
    prog(r_a, 0, ECC_CHUNK_BYTES);
    ecc_first = ecc_code;
    check("ecc written nonzero", ecc_first != '0, 1);
    readback(r_a, 0, ECC_CHUNK_BYTES);
    check("ecc code", ecc_code, ecc_first);
    check("ecc portions", ecc_pulses, 2);
    prog(r_c, PAGE_BYTES - 4, 4);
    readback(r_c, PAGE_BYTES - 6, 6);
    wp_allow = 1'b0;
    prog(r_a, 16, 4);
    wp_allow = 1'b1;
    readback(r_a, 14, 8);
    erase(r_c);
    wait_ok(1'b0);
    readback(r_c, PAGE_BYTES - 6, 6);
    slow = 1'b1;
    erase(r_a);
    wait_ok(1'b1);
    slow = 1'b0;
    readback(r_a, 0, 4);
    check("pad bits", u_nfh_flash_model.bad_pad, 0);
    check("read pace", u_nfh_flash_model.fast_rd, 0);
    print_verdict;
  end
  initial begin
    #500_000;
    failures++;
    print_verdict;
  end
endmodule : nand_flash_bus_interface_bench
`default_nettype wire
